// ---- src/lrc_pkg.sv ----
package lrc_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ           = 100;
    localparam int RST_PULSE_NS_X10  = 25000;  // 2.5 us in tenths of ns.
    localparam int HW_RECOVERY_US    = 1500;   // 1.5 ms.
    localparam int SW_RECOVERY_US    = 1000;   // 1 ms.
    localparam int BUS_FREE_NS       = 500;    // Bus free time before START.
    localparam int RST_PULSE_CYC     =
        (RST_PULSE_NS_X10 * CLK_MHZ + 9999) / 10000;
    localparam int HW_RECOVERY_CYC   = HW_RECOVERY_US * CLK_MHZ;
    localparam int SW_RECOVERY_CYC   = SW_RECOVERY_US * CLK_MHZ;
    localparam int BUS_FREE_CYC      = (BUS_FREE_NS * CLK_MHZ + 999) / 1000;
    localparam int QTR_DIV           = 25;     // 250 ns quarter bit, 1 us bit.

    // ==========================================================
    // Software reset call format
    // ==========================================================
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
    localparam logic [7:0] SOFT_RST_BYTE = 8'h06;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } lrc_pins_t;

    typedef struct packed {
        logic done;
        logic aborted;
    } lrc_result_t;

endpackage

// ---- src/lrc_byte_tx.sv ----
`timescale 1ns/1ps
// Sends one byte MSB first on an open-drain bus and samples the ninth bit.
module lrc_byte_tx (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       go,
    input  wire logic [7:0] data,
    input  wire logic       sda_in,
    output logic            busy,
    output logic            done,
    output logic            acked,
    output logic            scl_low,
    output logic            sda_low
);
    import lrc_pkg::*;

    logic [5:0] div_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg;
    logic       sda_reg;
    logic       tick;

    assign tick = (div_reg == 6'(QTR_DIV - 1));

    // ==========================================================
    // Quarter-bit sequencer
    // ==========================================================
    // Phases: 0 and 1 SCL low, 2 and 3 SCL high, ack sampled at end of 3.
    // SDA takes the first bit at go and otherwise moves only at the start of phase 1,
    // a quarter bit clear of both SCL edges, so a slave never sees data move as SCL falls.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            busy    <= 1'b0;
            done    <= 1'b0;
            acked   <= 1'b0;
            div_reg <= '0;
            ph_reg  <= '0;
            bit_reg <= '0;
            sh_reg  <= '0;
            sda_reg <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                div_reg <= '0;
                if (go) begin
                    busy    <= 1'b1;
                    sh_reg  <= data;
                    sda_reg <= !data[7];
                    bit_reg <= '0;
                    ph_reg  <= '0;
                end
            end else begin
                div_reg <= tick ? '0 : div_reg + 6'd1;
                if (tick) begin
                    ph_reg <= ph_reg + 2'd1;
                    if (ph_reg == 2'd0) begin
                        // The ninth bit is released for the acknowledge.
                        sda_reg <= (bit_reg != 4'd8) && !sh_reg[7];
                    end
                    if (ph_reg == 2'd3) begin
                        if (bit_reg == 4'd8) begin
                            acked <= !sda_in;
                            busy  <= 1'b0;
                            done  <= 1'b1;
                        end else begin
                            sh_reg <= {sh_reg[6:0], 1'b1};
                        end
                        bit_reg <= bit_reg + 4'd1;
                    end
                end
            end
        end
    end

    // SCL is pulled low in the first half of every bit.
    assign scl_low = busy && !ph_reg[1];
    assign sda_low = busy && sda_reg;
endmodule

// ---- src/lrc_reset_host.sv ----
`timescale 1ns/1ps
module lrc_reset_host #(
    parameter int HW_WAIT_CYC = lrc_pkg::HW_RECOVERY_CYC,
    parameter int SW_WAIT_CYC = lrc_pkg::SW_RECOVERY_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                hw_req,
    input  wire logic                sw_req,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output lrc_pkg::lrc_pins_t       pins,
    output logic                     dev_reset_b,
    output logic                     ready,
    output lrc_pkg::lrc_result_t     result
);
    import lrc_pkg::*;

    typedef enum {
        ST_BOOT, ST_IDLE, ST_PULSE, ST_HW_WAIT, ST_BUS_FREE, ST_START,
        ST_ADDR, ST_DATA, ST_STOP, ST_SW_WAIT
    } lrc_state_t;

    lrc_state_t  state_reg;
    logic [17:0] cnt_reg;
    logic [1:0]  scl_sync_reg;
    logic [1:0]  sda_sync_reg;
    logic        scl_s;
    logic        sda_s;
    logic        tx_go;
    logic [7:0]  tx_data;
    logic        tx_busy;
    logic        tx_done;
    logic        tx_acked;
    logic        tx_scl_low;
    logic        tx_sda_low;
    logic        ctl_scl_low;
    logic        ctl_sda_low;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Bus lines come from outside the clock domain; two stages each.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
        end
    end
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];

    // ==========================================================
    // Byte shifter
    // ==========================================================
    lrc_byte_tx u_tx (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .go      (tx_go),
        .data    (tx_data),
        .sda_in  (sda_s),
        .busy    (tx_busy),
        .done    (tx_done),
        .acked   (tx_acked),
        .scl_low (tx_scl_low),
        .sda_low (tx_sda_low)
    );

    assign tx_data = (state_reg == ST_ADDR) ? GEN_CALL_ADDR
                                            : SOFT_RST_BYTE;
    assign tx_go   = (state_reg == ST_ADDR || state_reg == ST_DATA)
                     && !tx_busy && !tx_done && cnt_reg == '0;

    // ==========================================================
    // Sequence control
    // ==========================================================
    // One counter serves every timed wait; it is reloaded per state.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= ST_BOOT;
            cnt_reg   <= '0;
            result    <= '0;
        end else begin
            cnt_reg <= (cnt_reg != '0) ? cnt_reg - 18'd1 : '0;
            unique case (state_reg)
                ST_BOOT: begin
                    state_reg <= ST_PULSE;
                    cnt_reg   <= 18'(RST_PULSE_CYC);
                end
                ST_IDLE: begin
                    if (hw_req) begin
                        state_reg <= ST_PULSE;
                        cnt_reg   <= 18'(RST_PULSE_CYC);
                        result    <= '0;
                    end else if (sw_req) begin
                        state_reg <= ST_BUS_FREE;
                        cnt_reg   <= 18'(BUS_FREE_CYC);
                        result    <= '0;
                    end
                end
                ST_PULSE: if (cnt_reg == '0) begin
                    state_reg <= ST_HW_WAIT;
                    cnt_reg   <= 18'(HW_WAIT_CYC);
                end
                ST_HW_WAIT: if (cnt_reg == '0) begin
                    state_reg   <= ST_IDLE;
                    result.done <= 1'b1;
                end
                ST_BUS_FREE: begin
                    if (!(scl_s && sda_s)) begin
                        cnt_reg <= 18'(BUS_FREE_CYC);
                    end else if (cnt_reg == '0) begin
                        state_reg <= ST_START;
                        cnt_reg   <= 18'(QTR_DIV * 2);
                    end
                end
                ST_START: if (cnt_reg == '0) begin
                    state_reg <= ST_ADDR;
                end
                ST_ADDR, ST_DATA: if (tx_done) begin
                    if (!tx_acked) begin
                        result.aborted <= 1'b1;
                    end
                    state_reg <= (tx_acked && state_reg == ST_ADDR)
                                 ? ST_DATA : ST_STOP;
                    cnt_reg   <= 18'(QTR_DIV * 2);
                end
                ST_STOP: if (cnt_reg == '0) begin
                    // An aborted call needs no recovery time.
                    state_reg <= result.aborted ? ST_IDLE : ST_SW_WAIT;
                    cnt_reg   <= 18'(SW_WAIT_CYC);
                end
                ST_SW_WAIT: if (cnt_reg == '0) begin
                    state_reg   <= ST_IDLE;
                    result.done <= 1'b1;
                end
            endcase
        end
    end

    // START: SDA falls with SCL high, then SCL low; STOP is the reverse.
    always_comb begin
        ctl_scl_low = 1'b0;
        ctl_sda_low = 1'b0;
        if (state_reg == ST_START) begin
            ctl_sda_low = 1'b1;
            ctl_scl_low = cnt_reg < 18'(QTR_DIV);
        end else if (state_reg == ST_STOP) begin
            ctl_sda_low = cnt_reg > 18'(QTR_DIV);
            ctl_scl_low = cnt_reg > 18'(QTR_DIV * 3 / 2);
        end else if ((state_reg == ST_ADDR || state_reg == ST_DATA)
                     && !tx_busy) begin
            // Between bytes SCL stays low, so no stray clock or bus edge
            // appears; SDA keeps the START level only before the address.
            ctl_scl_low = 1'b1;
            ctl_sda_low = (state_reg == ST_ADDR) && !tx_done;
        end
    end

    // Open drain: the drivers only ever pull low.
    assign pins = '{scl_o:  1'b0,
                    scl_oe: tx_scl_low | ctl_scl_low,
                    sda_o:  1'b0,
                    sda_oe: tx_sda_low | ctl_sda_low};
    assign dev_reset_b = !(state_reg == ST_PULSE);
    assign ready       = (state_reg == ST_IDLE);

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_pulse_start;
        $fell(dev_reset_b);
    endsequence

    // Cycles since the reset pin went high; a short recovery shows here.
    logic [17:0] rel_cnt_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !dev_reset_b) begin
            rel_cnt_reg <= '0;
        end else if (rel_cnt_reg != '1) begin
            rel_cnt_reg <= rel_cnt_reg + 18'd1;
        end
    end

    a_pulse_width: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        s_pulse_start |-> !dev_reset_b [*3])
        else $error("Reset pulse too short.");

    a_hw_wait: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        $rose(ready) && $past(state_reg) == ST_HW_WAIT
        |-> rel_cnt_reg >= 18'(HW_WAIT_CYC))
        else $error("Ready too soon after reset release.");

    a_idle_start: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        $changed(state_reg) && state_reg == ST_START |-> scl_s && sda_s)
        else $error("START issued on a busy bus.");

    a_sda_stable: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        tx_busy && $past(tx_busy) && !$past(pins.scl_oe)
        |-> $stable(pins.sda_oe))
        else $error("SDA moved while SCL high.");

    a_nack_abort: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        tx_done && !tx_acked |=> result.aborted)
        else $error("Nack did not abort the call.");

    a_abort_no_wait: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        state_reg == ST_STOP && result.aborted |-> ##[1:60] ready)
        else $error("Aborted call waited for recovery.");

    a_ack_release: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        tx_done |-> !$past(tx_sda_low))
        else $error("SDA driven during ack clock.");

    a_one_data: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        state_reg == ST_DATA && tx_done |=> state_reg == ST_STOP)
        else $error("Extra data byte sent.");

    a_sw_wait: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        $changed(state_reg) && state_reg == ST_SW_WAIT |-> !ready [*8])
        else $error("Ready too soon after soft reset call.");
endmodule

// ---- test/lrc_dev_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Device model: general call slave with a reset pin.
// ==========================================================
module lrc_dev_model (
    input  wire logic ref_clk,
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic reset_b,
    input  wire logic nack_addr,
    input  wire logic nack_data,
    output logic      sda_oe,
    output int        soft_cnt,
    output int        hw_cnt,
    output int        low_len
);
    logic       scl_q = 1'b1;
    logic       sda_q = 1'b1;
    logic       addr_ok = 1'b0;
    logic       armed = 1'b0;
    logic       ack_a;
    logic       ack_d;
    logic [7:0] sh = 8'h00;
    int         bit_n = 0;
    int         byte_n = 0;
    int         low_run = 0;

    initial begin
        sda_oe = 1'b0;
        soft_cnt = 0;
        hw_cnt = 0;
        low_len = 0;
    end

    // Acknowledge decisions; bytes after the second are never acked.
    assign ack_a = byte_n == 0 && sh == 8'h00 && !nack_addr;
    assign ack_d = byte_n == 1 && addr_ok && sh == 8'h06
                   && !nack_data;

    // Lines are sampled by the fast clock, as a real slave filters them.
    always @(posedge ref_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (!reset_b) begin
            low_run <= low_run + 1;
            bit_n   <= 0;
            byte_n  <= 0;
            armed   <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            if (low_run > 0) begin
                hw_cnt  <= hw_cnt + 1;
                low_len <= low_run;
            end
            low_run <= 0;
            if (scl && scl_q && sda_q && !sda) begin
                bit_n  <= 0;
                byte_n <= 0;
                armed  <= 1'b0;
            end else if (scl && scl_q && !sda_q && sda) begin
                soft_cnt <= soft_cnt + (armed ? 1 : 0);
                armed    <= 1'b0;
            end else if (scl && !scl_q) begin
                sh    <= (bit_n < 8) ? {sh[6:0], sda} : sh;
                bit_n <= bit_n + 1;
            end else if (!scl && scl_q && bit_n == 8) begin
                addr_ok <= ack_a;
                armed   <= ack_d;
                sda_oe  <= ack_a | ack_d;
            end else if (!scl && scl_q && bit_n == 9) begin
                sda_oe <= 1'b0;
                bit_n  <= 0;
                byte_n <= byte_n + 1;
            end
        end
    end
endmodule

// ---- test/tb_lrc_reset_host.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench: reset host against the device model.
// ==========================================================
module tb_lrc_reset_host;
    import lrc_pkg::*;
    localparam int HW_W = 20;
    localparam int SW_W = 20;
    // The model notes a pin change one edge late and since lags one more.
    localparam int LAG = 2;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hw_req = 1'b0;
    logic        sw_req = 1'b0;
    logic        nack_addr = 1'b0;
    logic        nack_data = 1'b0;
    logic        scl;
    logic        sda;
    logic        dev_oe;
    logic        dev_reset_b;
    logic        ready;
    lrc_pins_t   pins;
    lrc_result_t result;
    int          soft_cnt;
    int          hw_cnt;
    int          low_len;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          since = 0;
    int          last_evt = 0;
    int          exp_soft = 0;
    int          exp_hw = 1;
    logic [15:0] rnd = 16'hf9d2;

    always #5 ref_clk = ~ref_clk;

    // Both lines have pull-ups, so a released line reads high.
    assign scl = ~pins.scl_oe;
    assign sda = ~(pins.sda_oe | dev_oe);

    lrc_reset_host #(.HW_WAIT_CYC(HW_W), .SW_WAIT_CYC(SW_W)) i_lrc_reset_host (
        .ref_clk(ref_clk), .rst_b(rst_b), .hw_req(hw_req), .sw_req(sw_req),
        .scl_i(scl), .sda_i(sda), .pins(pins), .dev_reset_b(dev_reset_b),
        .ready(ready), .result(result));

    lrc_dev_model i_lrc_dev_model (
        .ref_clk(ref_clk), .scl(scl), .sda(sda), .reset_b(dev_reset_b),
        .nack_addr(nack_addr), .nack_data(nack_data), .sda_oe(dev_oe),
        .soft_cnt(soft_cnt), .hw_cnt(hw_cnt), .low_len(low_len));

    // Cycles since the device last left a reset; also the hang limit.
    always @(posedge ref_clk) begin
        cyc      <= cyc + 1;
        last_evt <= soft_cnt + hw_cnt;
        since    <= (soft_cnt + hw_cnt != last_evt) ? 0 : since + 1;
        if (cyc == 60000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Ready is combinational, so it is looked at on the falling edge.
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (ready !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        check(ready, 1'b1);
    endtask

    // Op 0 hardware, 1 good call, 2 address refused, 3 data refused.
    task automatic run(input int op);
        @(posedge ref_clk);
        nack_addr <= (op == 2);
        nack_data <= (op == 3);
        hw_req    <= (op == 0);
        sw_req    <= (op != 0);
        @(posedge ref_clk);
        hw_req <= 1'b0;
        sw_req <= 1'b0;
        // A second request while busy must be ignored.
        @(posedge ref_clk);
        hw_req <= (op != 0);
        sw_req <= (op == 0);
        @(posedge ref_clk);
        hw_req <= 1'b0;
        sw_req <= 1'b0;
        exp_hw   += (op == 0) ? 1 : 0;
        exp_soft += (op == 1) ? 1 : 0;
        wait_ready();
        check(hw_cnt, exp_hw);
        check(soft_cnt, exp_soft);
        if (op == 0) begin
            check(low_len >= RST_PULSE_CYC, 1'b1);
            check(since + LAG >= HW_W, 1'b1);
        end
        if (op == 1) begin
            check(since + LAG >= SW_W, 1'b1);
        end
        if (op < 2) begin
            check(result.done, 1'b1);
            check(result.aborted, 1'b0);
        end else begin
            check(result.aborted, 1'b1);
        end
        $display("test op %0d finished at %0t", op, $time);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Boot reset first, then every operation once, then random ones.
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        wait_ready();
        check(hw_cnt, 1);
        check(low_len >= RST_PULSE_CYC, 1'b1);
        check(since + LAG >= HW_W, 1'b1);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            run(i < 4 ? i : int'(rnd[1:0]));
        end
        results();
    end
endmodule
